// File: dv/rsam_props.sv
`timescale 1ns/1ps
`default_nettype none
module rsam_props (
  input wire logic        clock,                // Clock
  input wire logic        rst_n,                // Reset, active low
  input wire logic [5:0]  avs_address,          // Byte address
  input wire logic        avs_read,             // Read request
  input wire logic        avs_write,            // Write request
  input wire logic [31:0] avs_readdata,         // Read data
  input wire logic        avs_waitrequest,      // Stall
  input wire logic        ext_frame_trig_in,    // Trigger pin
  input wire logic        frame_trig_ready_out, // Waiting for frame start
  input wire logic        overtrigger_out,      // Dropped trigger pulse
  input wire logic        exposure_phase_out,   // Exposure active
  input wire logic        flash_window_out      // Flash window open
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_wq_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wq_one: assert property (p_wq_one) else $error("waitrequest low too long");
  property p_wq_ans; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_wq_ans: assert property (p_wq_ans) else $error("bus answer late");
  property p_unmap; avs_read && !avs_waitrequest && avs_address > 6'h20 |-> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ot_pulse; overtrigger_out |=> !overtrigger_out; endproperty
  a_ot_pulse: assert property (p_ot_pulse) else $error("overtrigger pulse too long");
  property p_ot_busy; overtrigger_out |-> !$past(frame_trig_ready_out); endproperty
  a_ot_busy: assert property (p_ot_busy) else $error("overtrigger while ready");
  sequence s_trig_rdy; $rose(ext_frame_trig_in) && frame_trig_ready_out ##1 frame_trig_ready_out [*3]; endsequence
  property p_take; s_trig_rdy |=> ##[0:2] !frame_trig_ready_out; endproperty
  a_take: assert property (p_take) else $error("trigger not taken");
  property p_exp; $fell(frame_trig_ready_out) |-> ##[1:6] exposure_phase_out; endproperty
  a_exp: assert property (p_exp) else $error("exposure did not follow");
  property p_fl_in_exp; flash_window_out |-> exposure_phase_out; endproperty
  a_fl_in_exp: assert property (p_fl_in_exp) else $error("flash outside exposure");
  c_take: cover property ($fell(frame_trig_ready_out));
  c_ot: cover property (overtrigger_out);
  c_flash: cover property ($rose(flash_window_out));
endmodule : rsam_props
bind rsam_top rsam_props i_props (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ext_frame_trig_in(ext_frame_trig_in),
  .frame_trig_ready_out(frame_trig_ready_out), .overtrigger_out(overtrigger_out),
  .exposure_phase_out(exposure_phase_out), .flash_window_out(flash_window_out));
`default_nettype wire

// File: dv/rsam_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rsam_top_tb;
  logic                           clock = 1'b0;
  logic                           rst_n = 1'b0;
  logic [5:0]                     avs_address = 6'h00;
  logic                           avs_read = 1'b0;
  logic                           avs_write = 1'b0;
  logic [31:0]                    avs_writedata = 32'h0;
  logic [31:0]                    avs_readdata, rdata;
  logic                           avs_waitrequest, ready, ot, expo, flash, trig;
  logic [rsam_pkg::NUM_LINES-1:0] line_out;
  int                             fail_count = 0;
  int                             checked = 0;
  int                             e_len, f_len, f_ofs, ot_seen;
  logic [5:0]                     ra [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h18, 6'h3c};
  logic [31:0]                    rv [6] = '{32'h0, 32'h3e8, 32'h23, 32'h10, 32'h230, 32'h0};
  logic [31:0]                    mc [3] = '{32'h24, 32'h25, 32'h2c};
  int                             ex_us [3] = '{26, 26, 20};
  int                             fo_us [3] = '{6, 0, 0};
  int                             fl_us [3] = '{14, 20, 20};
  always #2.5 clock = ~clock;
  always @(negedge clock) if (ot === 1'b1) ot_seen++;
  rsam_top i_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_frame_trig_in(trig),
    .frame_trig_ready_out(ready), .overtrigger_out(ot), .exposure_phase_out(expo),
    .flash_window_out(flash), .line_out(line_out));
  rsam_trig_src i_src (.clock(clock), .ready(ready), .trig(trig));
  task automatic summarize();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk32
  task automatic chkt(input int got, input int exp);
    checked++;
    if (got > exp + 100 || got < exp - 100) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chkt
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk32(rdata, exp);
  endtask : rdchk
  task automatic reboot();
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : reboot
  task automatic frame();
    int n;
    e_len = 0;
    f_len = 0;
    f_ofs = -1;
    fork i_src.fire(1'b1); join_none
    n = 0;
    while (expo !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    for (n = 0; n < 7000 && (expo === 1'b1 || flash === 1'b1 || n < 8); n++) begin
      if (expo === 1'b1) e_len++;
      if (flash === 1'b1) f_len++;
      if (flash === 1'b1 && f_ofs < 0) f_ofs = n;
      if (n == 4500) chk32({29'h0, line_out}, {29'h0, expo, flash, expo});
      @(negedge clock);
    end
  endtask : frame
  initial begin
    #300us;
    fail_count++;
    summarize();
  end
  initial begin
    reboot();
    for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
    for (int m = 0; m < 3; m++) begin
      reboot();
      bus(6'h04, 1'b1, 32'd20);
      bus(6'h08, 1'b1, 32'd2);
      bus(6'h0c, 1'b1, 32'd4);
      bus(6'h10, 1'b1, 32'd1);
      bus(6'h14, 1'b1, 32'd1);
      bus(6'h00, 1'b1, mc[m]);
      rdchk(6'h18, 32'd8);
      repeat (20) @(posedge clock);
      rdchk(6'h1c, 32'h1);
      frame();
      chkt(e_len, ex_us[m] * rsam_pkg::US_CYCLES);
      chkt(f_ofs, fo_us[m] * rsam_pkg::US_CYCLES);
      chkt(f_len, fl_us[m] * rsam_pkg::US_CYCLES);
      if (m == 0) begin
        chk32({31'h0, ready}, 32'h0);
        ot_seen = 0;
        i_src.fire(1'b0);
        repeat (10) @(posedge clock);
        chk32(ot_seen, 32'h1);
        chk32({31'h0, expo}, 32'h0);
        bus(6'h1c, 1'b0, 32'h0);
        chk32(rdata & 32'h4, 32'h4);
        bus(6'h1c, 1'b1, 32'h4);
        bus(6'h1c, 1'b0, 32'h0);
        chk32(rdata & 32'h4, 32'h0);
        // Free run: back-to-back frames, period equals exposure plus readout
        bus(6'h00, 1'b1, 32'h20);
        repeat (7000) @(posedge clock);
        rdchk(6'h20, 32'd28);
        bus(6'h1c, 1'b0, 32'h0);
        chk32(rdata & 32'h2, 32'h2);
      end
    end
    summarize();
  end
endmodule : rsam_top_tb
`default_nettype wire

// File: dv/rsam_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module rsam_trig_src (
  input  wire logic clock, // Device clock
  input  wire logic ready, // Device waiting for frame start
  output var  logic trig   // Frame start trigger pin
);
  initial trig = 1'b0;
  task automatic fire(input bit wait_rdy);
    if (wait_rdy) begin
      while (ready !== 1'b1) @(posedge clock);
    end
    @(posedge clock);
    trig <= 1'b1;
    repeat (6) @(posedge clock);
    trig <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : fire
endmodule : rsam_trig_src
`default_nettype wire

// File: hw/rsam_pkg.sv
// Operation
// R1: Overlap is allowed only in electronic rolling shutter mode, never global reset release.
// R2: On free-run-only variants, overlap needs both trigger modes off.
// R3: Without overlap, exposure plus readout ends before the next frame starts.
// R4: With overlap, a new frame starts while the previous one still completes.
// R5: Frame period runs from line-one exposure start to the next one.
// R6: Overlapped when period is at most exposure plus readout, otherwise not.
// R7: Readout duration in microseconds is readable for current settings.
// R8: Trigger source waits 400 us after line-one exposure end before triggering.
// R9: An early frame start trigger is dropped and raises an overtrigger event.
// R10: Trigger source should use the frame trigger ready output.
// R11: Global variant: exposure output spans each frame's exposure time.
// R12: Exposure output may lag exposure start and end by a fixed delay.
// R13: Rolling variant: exposure output spans first line start to last line end.
// R14: Rolling exposure output behaves the same in both shutter modes.
// R15: Flash window output is high exactly while the flash window is open.
// R16: Global variant: flash window output equals exposure output.
// R17: Software selects an output line, then assigns its source signal.
// R18: Rolling mode flash opens line shift times (height-1) after trigger, closes at exposure end.
// R19: Global reset release flash opens at trigger and lasts the exposure time.
// R20: Trigger ready rises on entering wait state, falls when a trigger is accepted.
// R21: Gap counter starts at line-one exposure end and gates trigger ready.
package rsam_pkg;
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          US_NS           = 1000;
  localparam int          US_CYCLES       = US_NS / CLK_PERIOD_NS;
  localparam int          GAP_MIN_US      = 400;
  localparam int          EXP_LAG_CYCLES  = 2;
  localparam int          TW              = 24;
  localparam int          NUM_LINES       = 3;
  localparam int          NUM_SLOTS       = 2;

  localparam logic [5:0]  OFS_CTRL        = 6'h00;
  localparam logic [5:0]  OFS_EXPOSURE    = 6'h04;
  localparam logic [5:0]  OFS_LINE_SHIFT  = 6'h08;
  localparam logic [5:0]  OFS_ROI_HEIGHT  = 6'h0c;
  localparam logic [5:0]  OFS_LINE_SEL    = 6'h10;
  localparam logic [5:0]  OFS_LINE_SRC    = 6'h14;
  localparam logic [5:0]  OFS_READOUT     = 6'h18;
  localparam logic [5:0]  OFS_STATUS      = 6'h1c;
  localparam logic [5:0]  OFS_PERIOD      = 6'h20;

  localparam int          CTRL_GRR        = 0;
  localparam int          CTRL_BURST_TRIG = 1;
  localparam int          CTRL_START_TRIG = 2;
  localparam int          CTRL_GLOBAL     = 3;
  localparam int          CTRL_FREE_ONLY  = 4;
  localparam int          CTRL_ACQ_EN     = 5;

  localparam int          ST_READY        = 0;
  localparam int          ST_OVERLAP      = 1;
  localparam int          ST_OVERTRIG     = 2;
  localparam int          ST_EXPOSURE     = 3;
  localparam int          ST_FLASH        = 4;

  localparam logic [5:0]  CTRL_RST        = 6'h00;
  localparam logic [23:0] EXPOSURE_RST    = 24'h0003e8;
  localparam logic [15:0] LINE_SHIFT_RST  = 16'h0023;
  localparam logic [11:0] ROI_HEIGHT_RST  = 12'h010;

  typedef struct packed {
    logic acq_en;
    logic free_only;
    logic global_sensor;
    logic start_trig_on;
    logic burst_trig_on;
    logic grr_mode;
  } rsam_cfg_s;
endpackage : rsam_pkg

// File: hw/rsam_top.sv
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rsam_top (
  input  wire logic                         clock,                // 200 MHz clock
  input  wire logic                         rst_n,                // Async reset, active low
  input  wire logic [5:0]                   avs_address,          // Byte address
  input  wire logic                         avs_read,             // Read request
  input  wire logic                         avs_write,            // Write request
  input  wire logic [31:0]                  avs_writedata,        // Write data
  input  wire logic [3:0]                   avs_byteenable,       // Byte lanes
  output logic [31:0]                       avs_readdata,         // Read data
  output logic                              avs_waitrequest,      // Stall
  input  wire logic                         ext_frame_trig_in,    // External frame start trigger pin
  output logic                              frame_trig_ready_out, // Waiting for frame start
  output logic                              overtrigger_out,      // Overtrigger event pulse
  output logic                              exposure_phase_out,   // Exposure active
  output logic                              flash_window_out,     // Flash window open
  output logic [rsam_pkg::NUM_LINES-1:0]    line_out              // Routed output lines
);
  localparam int TW = rsam_pkg::TW;
  localparam int NS = rsam_pkg::NUM_SLOTS;

  // Reset release
  logic [1:0] rst_sync_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else        rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire rst_ni = rst_sync_q[1];

  // Registers
  rsam_pkg::rsam_cfg_s               cfg_q;
  logic [TW-1:0]                     exposure_q;
  logic [15:0]                       line_shift_q;
  logic [11:0]                       roi_height_q;
  logic [1:0]                        line_sel_q;
  logic [rsam_pkg::NUM_LINES-1:0]    line_src_q;
  logic                              overtrig_q;
  logic [TW-1:0]                     period_q;
  logic                              waitreq_q;
  logic [31:0]                       rdata_q;

  // Derived timing, all in microseconds
  wire [27:0]    ro_full    = 28'(line_shift_q) * 28'(roi_height_q);
  wire [27:0]    sh_full    = 28'(line_shift_q) * 28'(roi_height_q - 12'h001);
  wire [TW-1:0]  readout_us = ro_full[TW-1:0];                 // [R7]
  wire [TW-1:0]  shift_us   = (roi_height_q == 12'h000) ? '0 : sh_full[TW-1:0];
  wire [TW-1:0]  last_end   = TW'(exposure_q + shift_us);
  wire [TW-1:0]  frame_end  = TW'(exposure_q + readout_us);

  // Microsecond tick
  logic [7:0] pre_q;
  wire        tick = (pre_q == 8'(rsam_pkg::US_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) pre_q <= 8'h00;
    else         pre_q <= tick ? 8'h00 : pre_q + 8'h01;
  end

  // Trigger pin synchroniser
  logic [2:0] trig_sync_q;
  logic       trig_lvl_q;
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      trig_sync_q <= 3'h0;
      trig_lvl_q  <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_frame_trig_in};
      if (trig_sync_q[1] == trig_sync_q[2]) trig_lvl_q <= trig_sync_q[2];
    end
  end
  wire trig_rise = trig_sync_q[1] & trig_sync_q[2] & ~trig_lvl_q;

  // Overlap permission
  wire free_run   = ~cfg_q.burst_trig_on & ~cfg_q.start_trig_on;
  wire overlap_ok = ~cfg_q.grr_mode                                // [R1]
                  & (~cfg_q.free_only | free_run);                 // [R2]

  // Frame slots
  logic [NS-1:0] busy_q;
  logic [TW-1:0] t_q [NS];
  logic [NS-1:0] exp_on;
  logic [NS-1:0] fl_on;
  logic [NS-1:0] l1_end;
  logic [NS-1:0] done;
  logic [NS-1:0] start_slot;
  logic          ready_q;

  wire any_busy  = |busy_q;
  wire all_busy  = &busy_q;
  wire ext_req   = cfg_q.start_trig_on & trig_rise;
  wire int_req   = ~cfg_q.start_trig_on & cfg_q.acq_en;
  wire start_now = ready_q & (ext_req | int_req);
  wire ovt_evt   = ext_req & ~ready_q;                             // [R9]

  assign start_slot = busy_q[0] ? 2'b10 : 2'b01;

  generate
    for (genvar i = 0; i < NS; i++) begin : g_slot
      wire [TW-1:0] t = t_q[i];
      wire rs_exp  = (t < last_end);                               // [R13] [R14]
      wire gs_exp  = (t < exposure_q);                             // [R11]
      wire ers_fl  = (t >= shift_us) && (t < exposure_q);          // [R18]
      wire grr_fl  = (t < exposure_q);                             // [R19]
      assign exp_on[i] = busy_q[i] & (cfg_q.global_sensor ? gs_exp : rs_exp);
      assign fl_on[i]  = busy_q[i] & (cfg_q.global_sensor ? gs_exp  // [R16]
                                     : (cfg_q.grr_mode ? grr_fl : ers_fl));
      assign l1_end[i] = busy_q[i] & tick & (t == exposure_q);
      assign done[i]   = busy_q[i] & (t >= frame_end);             // [R3]

      always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
          busy_q[i] <= 1'b0;
          t_q[i]    <= '0;
        end else if (start_now && start_slot[i]) begin             // [R4]
          busy_q[i] <= 1'b1;
          t_q[i]    <= '0;
        end else if (done[i]) begin
          busy_q[i] <= 1'b0;
        end else if (busy_q[i] && tick) begin
          t_q[i]    <= t_q[i] + 24'h000001;
        end
      end
    end
  endgenerate

  // Gap after line-one exposure end
  logic [TW-1:0] gap_q;
  logic          gap_arm_q;
  wire           gap_ok = (gap_q >= TW'(rsam_pkg::GAP_MIN_US));   // [R8]
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      gap_q     <= '0;
      gap_arm_q <= 1'b0;
    end else if (start_now) begin
      gap_q     <= '0;
      gap_arm_q <= 1'b0;
    end else if (|l1_end) begin                                    // [R21]
      gap_q     <= '0;
      gap_arm_q <= 1'b1;
    end else if (gap_arm_q && tick && !gap_ok) begin
      gap_q     <= gap_q + 24'h000001;
    end
  end

  // Trigger ready
  wire ready_d = cfg_q.acq_en & ~start_now
               & (~any_busy                                        // [R3]
               | (overlap_ok & gap_arm_q & gap_ok & ~all_busy));   // [R21]
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) ready_q <= 1'b0;
    else         ready_q <= ready_d;                               // [R20]
  end

  // Frame period
  logic [TW-1:0] per_cnt_q;
  logic          per_valid_q;
  wire           per_sat = &per_cnt_q;
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      per_cnt_q   <= '0;
      period_q    <= '0;
      per_valid_q <= 1'b0;
    end else if (start_now) begin
      per_cnt_q   <= '0;
      per_valid_q <= 1'b1;
      if (per_valid_q) period_q <= per_cnt_q;                      // [R5]
    end else if (tick && !per_sat) begin
      per_cnt_q   <= per_cnt_q + 24'h000001;
    end
  end
  wire overlapped = per_valid_q & (period_q <= frame_end);         // [R6]

  // Exposure and flash outputs with fixed lag
  localparam int LG = rsam_pkg::EXP_LAG_CYCLES;
  logic [LG-1:0] exp_dly_q;
  logic [LG-1:0] fl_dly_q;
  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      exp_dly_q <= '0;
      fl_dly_q  <= '0;
    end else begin
      exp_dly_q <= {exp_dly_q[LG-2:0], |exp_on};                   // [R12]
      fl_dly_q  <= {fl_dly_q[LG-2:0], |fl_on};                     // [R15]
    end
  end
  wire exp_now = exp_dly_q[LG-1];
  wire fl_now  = fl_dly_q[LG-1];

  logic [rsam_pkg::NUM_LINES-1:0] line_d;
  generate
    for (genvar j = 0; j < rsam_pkg::NUM_LINES; j++) begin : g_line
      assign line_d[j] = line_src_q[j] ? fl_now : exp_now;         // [R17]
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      exposure_phase_out <= 1'b0;
      flash_window_out   <= 1'b0;
      line_out           <= '0;
      overtrigger_out    <= 1'b0;
    end else begin
      exposure_phase_out <= exp_now;
      flash_window_out   <= fl_now;
      line_out           <= line_d;
      overtrigger_out    <= ovt_evt;                               // [R9]
    end
  end
  assign frame_trig_ready_out = ready_q;                           // [R10]

  // Avalon-MM slave, one wait state
  wire        req    = avs_read | avs_write;
  wire        acc    = req & ~waitreq_q;
  wire        wr_acc = acc & avs_write;
  wire [31:0] wd     = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        w_ctrl = wr_acc & (avs_address == rsam_pkg::OFS_CTRL);
  wire        w_exp  = wr_acc & (avs_address == rsam_pkg::OFS_EXPOSURE);
  wire        w_ls   = wr_acc & (avs_address == rsam_pkg::OFS_LINE_SHIFT);
  wire        w_roi  = wr_acc & (avs_address == rsam_pkg::OFS_ROI_HEIGHT);
  wire        w_sel  = wr_acc & (avs_address == rsam_pkg::OFS_LINE_SEL);
  wire        w_src  = wr_acc & (avs_address == rsam_pkg::OFS_LINE_SRC);
  wire        w_stat = wr_acc & (avs_address == rsam_pkg::OFS_STATUS);
  wire        sel_ok = (line_sel_q < 2'(rsam_pkg::NUM_LINES));

  wire [31:0] status_w = 32'({fl_now, exp_now, overtrig_q, overlapped, ready_q});
  wire [31:0] rd_mux =
      (avs_address == rsam_pkg::OFS_CTRL)       ? 32'(cfg_q)        :
      (avs_address == rsam_pkg::OFS_EXPOSURE)   ? 32'(exposure_q)   :
      (avs_address == rsam_pkg::OFS_LINE_SHIFT) ? 32'(line_shift_q) :
      (avs_address == rsam_pkg::OFS_ROI_HEIGHT) ? 32'(roi_height_q) :
      (avs_address == rsam_pkg::OFS_LINE_SEL)   ? 32'(line_sel_q)   :
      (avs_address == rsam_pkg::OFS_LINE_SRC)   ? 32'(sel_ok & line_src_q[line_sel_q]) :
      (avs_address == rsam_pkg::OFS_READOUT)    ? 32'(readout_us)   :
      (avs_address == rsam_pkg::OFS_STATUS)     ? status_w          :
      (avs_address == rsam_pkg::OFS_PERIOD)     ? 32'(period_q)     : 32'h00000000;

  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h00000000;
    end else begin
      waitreq_q <= ~(req & waitreq_q);
      if (req && waitreq_q) rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = waitreq_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clock or negedge rst_ni) begin
    if (!rst_ni) begin
      cfg_q        <= rsam_pkg::CTRL_RST;
      exposure_q   <= rsam_pkg::EXPOSURE_RST;
      line_shift_q <= rsam_pkg::LINE_SHIFT_RST;
      roi_height_q <= rsam_pkg::ROI_HEIGHT_RST;
      line_sel_q   <= 2'h0;
      line_src_q   <= '0;
      overtrig_q   <= 1'b0;
    end else begin
      if (w_ctrl) cfg_q        <= rsam_pkg::rsam_cfg_s'(wd[5:0]);
      if (w_exp)  exposure_q   <= wd[TW-1:0];
      if (w_ls)   line_shift_q <= wd[15:0];
      if (w_roi)  roi_height_q <= wd[11:0];
      if (w_sel)  line_sel_q   <= wd[1:0];
      if (w_src && sel_ok) line_src_q[line_sel_q] <= wd[0];        // [R17]
      // Set wins over write-one clear
      if (ovt_evt)                          overtrig_q <= 1'b1;
      else if (w_stat && wd[rsam_pkg::ST_OVERTRIG]) overtrig_q <= 1'b0;
    end
  end
endmodule : rsam_top
`default_nettype wire
